// ===== shared/acm_regs.vh
`ifndef ACM_REGS_VH
`define ACM_REGS_VH

// ****************************************
// Operation codes
// ****************************************
`define ACM_OP_W 3
`define ACM_OP_HEX_TO_ASCII 3'h0
`define ACM_OP_SEVEN_SEG 3'h1
`define ACM_OP_GRAY 3'h2
`define ACM_OP_SHUFFLE 3'h3
`define ACM_OP_WORD_COPY 3'h4
`define ACM_OP_LABEL_COPY 3'h5

// ****************************************
// Field layout and constants
// ****************************************
`define ACM_ACC_W 32
`define ACM_WORD_W 16
`define ACM_ADDR_W 16
`define ACM_LEFT_W 17
`define ACM_DIGITS 8
`define ACM_GRAY_RES_W 10
`define ACM_ASCII_DIGIT_BASE 8'h30
`define ACM_ASCII_ALPHA_BASE 8'h41
`define ACM_NIB_TEN 4'hA
`define ACM_ORDER_MAX 4'h8
`define ACM_FIFO_DEPTH 4
`define ACM_FIFO_AW 2

`endif

// ===== hdl/acm_fifo.v
`timescale 1ns/1ps
`default_nettype none
module acm_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rd_ptr_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointers wrap by compare so depth need not be a power of two
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	always @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/acm_core.v
`timescale 1ns/1ps
`default_nettype none
`include "acm_regs.vh"
module acm_core #(
	parameter FIFO_DEPTH = `ACM_FIFO_DEPTH,
	parameter FIFO_AW = `ACM_FIFO_AW
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire op_start_i,
	input wire [`ACM_OP_W-1:0] op_code_i,
	input wire [`ACM_ACC_W-1:0] acc_i,
	input wire [`ACM_ACC_W-1:0] stack1_i,
	input wire [`ACM_ACC_W-1:0] stack2_i,
	input wire [`ACM_ADDR_W-1:0] operand_i,
	input wire src_is_label_i,
	output wire busy_o,
	output wire done_o,
	output wire acc_valid_o,
	output wire [`ACM_ACC_W-1:0] acc_o,
	output wire rd_req_o,
	output wire rd_label_o,
	output wire [`ACM_ADDR_W-1:0] rd_addr_o,
	input wire [`ACM_WORD_W-1:0] rd_data_i,
	output wire wr_req_o,
	output wire wr_label_o,
	output wire [`ACM_ADDR_W-1:0] wr_addr_o,
	output wire [`ACM_WORD_W-1:0] wr_data_o,
	input wire wr_ready_i
);
	// ****************************************
	// States
	// ****************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_COPY = 2'b01;
	localparam ST_DONE = 2'b10;

	// ****************************************
	// Conversion functions
	// ****************************************
	function [7:0] hex_ascii;
		input [3:0] nib;
		begin
			if (nib < `ACM_NIB_TEN) begin
				hex_ascii = `ACM_ASCII_DIGIT_BASE + {4'h0, nib};
			end else begin
				hex_ascii = `ACM_ASCII_ALPHA_BASE + {4'h0, nib - `ACM_NIB_TEN};
			end
		end
	endfunction

	function [7:0] seg_pattern;
		input [3:0] nib;
		begin
			// Segment a in bit 0 through g in bit 6, bit 7 unused
			case (nib)
				4'h0: seg_pattern = 8'h3F;
				4'h1: seg_pattern = 8'h06;
				4'h2: seg_pattern = 8'h5B;
				4'h3: seg_pattern = 8'h4F;
				4'h4: seg_pattern = 8'h66;
				4'h5: seg_pattern = 8'h6D;
				4'h6: seg_pattern = 8'h7D;
				4'h7: seg_pattern = 8'h07;
				4'h8: seg_pattern = 8'h7F;
				4'h9: seg_pattern = 8'h6F;
				4'hA: seg_pattern = 8'h77;
				4'hB: seg_pattern = 8'h7C;
				4'hC: seg_pattern = 8'h39;
				4'hD: seg_pattern = 8'h5E;
				4'hE: seg_pattern = 8'h79;
				default: seg_pattern = 8'h71;
			endcase
		end
	endfunction

	function [`ACM_ACC_W-1:0] seven_segment_convert;
		input [`ACM_ACC_W-1:0] acc;
		integer i;
		begin
			seven_segment_convert = {`ACM_ACC_W{1'b0}};
			for (i = 0; i < 4; i = i + 1) begin
				seven_segment_convert[i*8 +: 8] = seg_pattern(acc[i*4 +: 4]);
			end
		end
	endfunction

	function [`ACM_ACC_W-1:0] gray_to_bcd;
		input [`ACM_ACC_W-1:0] acc;
		reg [15:0] bin;
		reg [15:0] bcd;
		integer i;
		begin
			bin = 16'h0000;
			bcd = 16'h0000;
			gray_to_bcd = {`ACM_ACC_W{1'b0}};
			bin[15] = acc[15];
			for (i = 14; i >= 0; i = i - 1) begin
				bin[i] = bin[i+1] ^ acc[i];
			end
			// Shift-add-three over the low ten binary bits
			for (i = `ACM_GRAY_RES_W - 1; i >= 0; i = i - 1) begin
				if (bcd[3:0] > 4'h4) bcd[3:0] = bcd[3:0] + 4'h3;
				if (bcd[7:4] > 4'h4) bcd[7:4] = bcd[7:4] + 4'h3;
				if (bcd[11:8] > 4'h4) bcd[11:8] = bcd[11:8] + 4'h3;
				bcd = {bcd[14:0], bin[i]};
			end
			// No resolution correction applied here; 360 and 720 counts are the program's job
			gray_to_bcd[`ACM_GRAY_RES_W-1:0] = bcd[`ACM_GRAY_RES_W-1:0];
		end
	endfunction

	function [`ACM_ACC_W-1:0] digit_shuffle;
		input [`ACM_ACC_W-1:0] src;
		input [`ACM_ACC_W-1:0] order;
		reg [3:0] k;
		integer i;
		integer j;
		begin
			k = 4'h0;
			digit_shuffle = {`ACM_ACC_W{1'b0}};
			// Ascending scan, so a later (more significant) duplicate overwrites
			for (i = 0; i < `ACM_DIGITS; i = i + 1) begin
				k = order[i*4 +: 4];
				for (j = 0; j < `ACM_DIGITS; j = j + 1) begin
					if (k != 4'h0 && k <= `ACM_ORDER_MAX && k == j + 1) begin
						digit_shuffle[j*4 +: 4] = src[i*4 +: 4];
					end
				end
			end
		end
	endfunction

	function [`ACM_ADDR_W-1:0] add_addr;
		input [`ACM_ADDR_W-1:0] a;
		input [`ACM_ADDR_W-1:0] b;
		reg [`ACM_ADDR_W:0] sum;
		begin
			sum = {1'b0, a} + {1'b0, b};
			add_addr = sum[`ACM_ADDR_W-1:0];
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [`ACM_OP_W-1:0] mode_q;
	reg [`ACM_ADDR_W-1:0] src_addr_q;
	reg [`ACM_ADDR_W-1:0] dst_addr_q;
	reg [`ACM_LEFT_W-1:0] rd_left_q;
	reg [`ACM_LEFT_W-1:0] wr_left_q;
	reg rd_req_q;
	reg rd_pend_q;
	reg rd_label_q;
	reg wr_req_q;
	reg wr_label_q;
	reg [`ACM_ADDR_W-1:0] wr_addr_q;
	reg [`ACM_WORD_W-1:0] wr_data_q;
	reg half_q;
	reg busy_q;
	reg done_q;
	reg acc_valid_q;
	reg [`ACM_ACC_W-1:0] acc_q;

	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`ACM_WORD_W-1:0] fifo_out_data;
	wire is_hta;
	wire wr_fire;
	wire wr_load;
	wire fifo_pop;
	wire rd_issue;
	wire start_copy;
	wire start_acc;

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign acc_valid_o = acc_valid_q;
	assign acc_o = acc_q;
	assign rd_req_o = rd_req_q;
	assign rd_label_o = rd_label_q;
	assign rd_addr_o = src_addr_q;
	assign wr_req_o = wr_req_q;
	assign wr_label_o = wr_label_q;
	assign wr_addr_o = wr_addr_q;
	assign wr_data_o = wr_data_q;

	assign is_hta = (mode_q == `ACM_OP_HEX_TO_ASCII);
	assign start_copy = (state_q == ST_IDLE) && op_start_i &&
		(op_code_i == `ACM_OP_HEX_TO_ASCII || op_code_i == `ACM_OP_WORD_COPY ||
		op_code_i == `ACM_OP_LABEL_COPY);
	assign start_acc = (state_q == ST_IDLE) && op_start_i &&
		(op_code_i == `ACM_OP_SEVEN_SEG || op_code_i == `ACM_OP_GRAY ||
		op_code_i == `ACM_OP_SHUFFLE);
	// One read in flight at a time, and only while the FIFO can take its answer
	assign rd_issue = (state_q == ST_COPY) && (rd_left_q != {`ACM_LEFT_W{1'b0}}) &&
		!rd_req_q && !rd_pend_q && fifo_in_ready;
	assign wr_fire = wr_req_q && wr_ready_i;
	assign wr_load = (state_q == ST_COPY) && fifo_out_valid && (!wr_req_q || wr_fire);
	assign fifo_pop = wr_load && (!is_hta || half_q);

	// ****************************************
	// Data path buffer
	// ****************************************
	acm_fifo #(
		.WIDTH(`ACM_WORD_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(rd_pend_q),
		.in_ready_o(fifo_in_ready),
		.in_data_i(rd_data_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_out_data)
	);

	// ****************************************
	// Sequencing
	// ****************************************
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_copy) begin
					state_d = ST_COPY;
				end
			end
			ST_COPY: begin
				if (wr_left_q == {`ACM_LEFT_W{1'b0}}) begin
					state_d = ST_DONE;
				end else if (wr_fire && wr_left_q == {{(`ACM_LEFT_W-1){1'b0}}, 1'b1}) begin
					state_d = ST_DONE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			mode_q <= `ACM_OP_WORD_COPY;
			src_addr_q <= {`ACM_ADDR_W{1'b0}};
			dst_addr_q <= {`ACM_ADDR_W{1'b0}};
			rd_left_q <= {`ACM_LEFT_W{1'b0}};
			rd_label_q <= 1'b0;
			wr_label_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			acc_valid_q <= 1'b0;
			acc_q <= {`ACM_ACC_W{1'b0}};
		end else begin
			state_q <= state_d;
			done_q <= (state_q == ST_COPY) && (state_d == ST_DONE);
			busy_q <= (state_d == ST_COPY);
			acc_valid_q <= start_acc;
			if (start_acc) begin
				case (op_code_i)
					`ACM_OP_SEVEN_SEG: acc_q <= seven_segment_convert(acc_i);
					`ACM_OP_GRAY: acc_q <= gray_to_bcd(acc_i);
					default: acc_q <= digit_shuffle(stack1_i, acc_i);
				endcase
			end
			if (start_copy) begin
				mode_q <= op_code_i;
				if (op_code_i == `ACM_OP_LABEL_COPY) begin
					// Count from level two, offset from level one, as pushed by the loads
					rd_left_q <= {1'b0, stack2_i[`ACM_ADDR_W-1:0]};
					src_addr_q <= add_addr(acc_i[`ACM_ADDR_W-1:0],
						stack1_i[`ACM_ADDR_W-1:0]);
					dst_addr_q <= add_addr(operand_i, stack1_i[`ACM_ADDR_W-1:0]);
					rd_label_q <= src_is_label_i;
					wr_label_q <= !src_is_label_i;
				end else begin
					rd_left_q <= {1'b0, stack1_i[`ACM_ADDR_W-1:0]};
					src_addr_q <= acc_i[`ACM_ADDR_W-1:0];
					dst_addr_q <= operand_i;
					rd_label_q <= 1'b0;
					wr_label_q <= 1'b0;
				end
			end else if (rd_issue) begin
				// No range check: out-of-area reads return whatever memory holds
				rd_left_q <= rd_left_q - 1'b1;
			end
			if (rd_req_q) begin
				src_addr_q <= src_addr_q + 1'b1;
			end
			if (wr_load) begin
				dst_addr_q <= dst_addr_q + 1'b1;
			end
		end
	end

	// ****************************************
	// Memory read and write ports
	// ****************************************
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_req_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_left_q <= {`ACM_LEFT_W{1'b0}};
			wr_req_q <= 1'b0;
			wr_addr_q <= {`ACM_ADDR_W{1'b0}};
			wr_data_q <= {`ACM_WORD_W{1'b0}};
			half_q <= 1'b0;
		end else begin
			rd_req_q <= rd_issue;
			rd_pend_q <= rd_req_q;
			if (start_copy) begin
				half_q <= 1'b0;
				if (op_code_i == `ACM_OP_HEX_TO_ASCII) begin
					// Two ASCII words for every hex word read
					wr_left_q <= {stack1_i[`ACM_ADDR_W-1:0], 1'b0};
				end else if (op_code_i == `ACM_OP_LABEL_COPY) begin
					wr_left_q <= {1'b0, stack2_i[`ACM_ADDR_W-1:0]};
				end else begin
					wr_left_q <= {1'b0, stack1_i[`ACM_ADDR_W-1:0]};
				end
			end else if (wr_fire) begin
				wr_left_q <= wr_left_q - 1'b1;
			end
			if (wr_load) begin
				wr_req_q <= 1'b1;
				wr_addr_q <= dst_addr_q;
				if (is_hta) begin
					half_q <= !half_q;
					// More significant digit pair goes to the lower address
					if (!half_q) begin
						wr_data_q <= {hex_ascii(fifo_out_data[15:12]),
							hex_ascii(fifo_out_data[11:8])};
					end else begin
						wr_data_q <= {hex_ascii(fifo_out_data[7:4]),
							hex_ascii(fifo_out_data[3:0])};
					end
				end else begin
					wr_data_q <= fifo_out_data;
				end
			end else if (wr_fire) begin
				wr_req_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verification/acm_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "acm_regs.vh"
module acm_core_assertions #(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic op_start_i,
	input wire logic [`ACM_OP_W-1:0] op_code_i,
	input wire logic [`ACM_ACC_W-1:0] acc_i,
	input wire logic [`ACM_ACC_W-1:0] stack1_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic acc_valid_o,
	input wire logic [`ACM_ACC_W-1:0] acc_o,
	input wire logic rd_req_o,
	input wire logic wr_req_o,
	input wire logic [`ACM_ADDR_W-1:0] wr_addr_o,
	input wire logic [`ACM_WORD_W-1:0] wr_data_o,
	input wire logic wr_ready_i
);
	// ****************
	// Accepted starts
	// ****************
	wire st = op_start_i && !busy_o && !done_o;
	wire st_acc = st && op_code_i >= `ACM_OP_SEVEN_SEG && op_code_i <= `ACM_OP_SHUFFLE;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_acc_valid; st_acc |=> acc_valid_o; endproperty
	a_acc_valid: assert property (p_acc_valid) else $error("no result pulse");
	property p_valid_cause; acc_valid_o |-> $past(st_acc); endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("stray result");
	property p_seg_top; st && op_code_i == `ACM_OP_SEVEN_SEG |=>
		!acc_o[7] && !acc_o[15] && !acc_o[23] && !acc_o[31]; endproperty
	a_seg_top: assert property (p_seg_top) else $error("segment bit 7 set");
	property p_gray_hi; st && op_code_i == `ACM_OP_GRAY |=> acc_o[31:10] == 22'h0; endproperty
	a_gray_hi: assert property (p_gray_hi) else $error("gray upper bits");
	property p_shuf_zero; st && op_code_i == `ACM_OP_SHUFFLE && acc_i == 32'h0 |=>
		acc_o == 32'h0; endproperty
	a_shuf_zero: assert property (p_shuf_zero) else $error("shuffle not zero");
	property p_shuf_ident; st && op_code_i == `ACM_OP_SHUFFLE && acc_i == 32'h87654321 |=>
		acc_o == $past(stack1_i); endproperty
	a_shuf_ident: assert property (p_shuf_ident) else $error("shuffle order");
	property p_count0; st && op_code_i == `ACM_OP_WORD_COPY && stack1_i[15:0] == 16'h0 |=>
		busy_o ##1 (done_o && !busy_o); endproperty
	a_count0: assert property (p_count0) else $error("empty copy timing");
	property p_rd_pulse; rd_req_o |=> !rd_req_o; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe long");
	property p_wr_hold; wr_req_o && !wr_ready_i |=>
		wr_req_o && $stable(wr_addr_o) && $stable(wr_data_o); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write dropped");
	property p_done; done_o |-> !busy_o ##1 !done_o; endproperty
	a_done: assert property (p_done) else $error("done pulse");
	c_label: cover property (st && op_code_i == `ACM_OP_LABEL_COPY);
	c_stall: cover property (wr_req_o && !wr_ready_i);
	c_shuf: cover property (st && op_code_i == `ACM_OP_SHUFFLE);
endmodule
bind acm_core acm_core_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .op_start_i(op_start_i), .op_code_i(op_code_i),
	.acc_i(acc_i), .stack1_i(stack1_i), .busy_o(busy_o), .done_o(done_o),
	.acc_valid_o(acc_valid_o), .acc_o(acc_o), .rd_req_o(rd_req_o), .wr_req_o(wr_req_o),
	.wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i));
`default_nettype wire

// ===== verification/acm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module acm_mem_model (
	input wire logic clk_i,
	input wire logic rd_req_i,
	input wire logic rd_label_i,
	input wire logic [15:0] rd_addr_i,
	output logic [15:0] rd_data_o,
	input wire logic wr_req_i,
	input wire logic wr_label_i,
	input wire logic [15:0] wr_addr_i,
	input wire logic [15:0] wr_data_i,
	output logic wr_ready_o,
	input wire logic stall_i
);
	// Only 256 words each; tests keep addresses low
	logic [15:0] wm [0:255];
	logic [15:0] lm [0:255];
	initial rd_data_o = 16'h0;
	initial wr_ready_o = 1'b0;
	always @(posedge clk_i) begin
		// Data valid one cycle only, then scrambled
		if (rd_req_i) begin
			rd_data_o <= rd_label_i ? lm[rd_addr_i[7:0]] : wm[rd_addr_i[7:0]];
		end else begin
			rd_data_o <= ~rd_data_o;
		end
		wr_ready_o <= stall_i ? 1'($urandom_range(1)) : 1'b1;
		if (wr_req_i && wr_ready_o) begin
			if (wr_label_i) lm[wr_addr_i[7:0]] <= wr_data_i;
			else wm[wr_addr_i[7:0]] <= wr_data_i;
		end
	end
endmodule
`default_nettype wire

// ===== verification/acm_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acm_core_tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0, op_start_i = 1'b0, src_is_label_i = 1'b0, stall = 1'b0;
	logic [2:0] op_code_i = 3'h0;
	logic [31:0] acc_i = 32'h0, stack1_i = 32'h0, stack2_i = 32'h0;
	logic [15:0] operand_i = 16'h0;
	wire busy_o, done_o, acc_valid_o, rd_req_o, rd_label_o, wr_req_o, wr_label_o, wr_ready_i;
	wire [31:0] acc_o;
	wire [15:0] rd_addr_o, rd_data_i, wr_addr_o, wr_data_o;
	int errors = 0, n_tests = 0;
	logic [15:0] ew [0:255];
	logic [15:0] el [0:255];
	localparam logic [127:0] SEGT = 128'h71795E397C776F7F077D6D664F5B063F;
	acm_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_start_i(op_start_i),
		.op_code_i(op_code_i), .acc_i(acc_i), .stack1_i(stack1_i), .stack2_i(stack2_i),
		.operand_i(operand_i), .src_is_label_i(src_is_label_i), .busy_o(busy_o),
		.done_o(done_o), .acc_valid_o(acc_valid_o), .acc_o(acc_o), .rd_req_o(rd_req_o),
		.rd_label_o(rd_label_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
		.wr_req_o(wr_req_o), .wr_label_o(wr_label_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i));
	acm_mem_model m (.clk_i(clk_i), .rd_req_i(rd_req_o), .rd_label_i(rd_label_o),
		.rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i), .wr_req_i(wr_req_o),
		.wr_label_i(wr_label_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
		.wr_ready_o(wr_ready_i), .stall_i(stall));
	initial forever #5 clk_i = ~clk_i;
	function automatic logic [7:0] asc(input logic [3:0] n);
		return n < 4'hA ? 8'h30 + n : 8'h37 + n;
	endfunction
	function automatic logic [31:0] model(input logic [2:0] op, input logic [31:0] a, s);
		logic [31:0] r;
		logic [15:0] b;
		int k, v;
		r = 32'h0;
		case (op)
			3'h1: for (int i = 0; i < 4; i++) r[8*i +: 8] = SEGT[8*a[4*i +: 4] +: 8];
			3'h2: begin
				b[15] = a[15];
				for (int i = 14; i >= 0; i--) b[i] = b[i+1] ^ a[i];
				v = b[9:0];
				r = v % 10 + (v / 10 % 10) * 16 + (v / 100 % 10) * 256;
				r[31:10] = 22'h0;
			end
			3'h3: for (int i = 0; i < 8; i++) begin
				k = a[4*i +: 4];
				if (k >= 1 && k <= 8) r[4*(k-1) +: 4] = s[4*i +: 4];
			end
			default: r = 32'h0;
		endcase
		return r;
	endfunction
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic acc_op(input logic [2:0] op, input logic [31:0] a, s);
		op_start_i = 1'b1;
		op_code_i = op;
		acc_i = a;
		stack1_i = s;
		// Start stays up so back-to-back calls never toggle it within one time step
		@(negedge clk_i);
		chk(acc_valid_o === 1'b1 && acc_o === model(op, a, s), "accumulator result");
	endtask
	task automatic copy(input logic [2:0] op, input logic lab, input logic [15:0] a, s1, s2, d);
		int n;
		logic ok;
		op_start_i = 1'b1;
		op_code_i = op;
		src_is_label_i = lab;
		acc_i = {16'h0, a};
		stack1_i = {16'h0, s1};
		stack2_i = {16'h0, s2};
		operand_i = d;
		@(negedge clk_i);
		// Second start lands while busy and must vanish
		op_code_i = 3'h1;
		@(negedge clk_i);
		op_start_i = 1'b0;
		chk(acc_valid_o === 1'b0, "start taken while busy");
		n = 0;
		while (done_o !== 1'b1 && n < 3000) begin
			@(negedge clk_i);
			n++;
		end
		chk(n < 3000, "copy never finished");
		@(negedge clk_i);
		ok = 1'b1;
		for (int i = 0; i < 256; i++) ok &= m.wm[i] === ew[i] && m.lm[i] === el[i];
		chk(ok, "memory contents");
		$display("copy op %0d done", op);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h3C79FC49));
		for (int i = 0; i < 256; i++) begin
			m.wm[i] = 16'($urandom);
			m.lm[i] = 16'($urandom);
		end
		m.wm[150] = 16'h0123;
		m.wm[151] = 16'h4567;
		m.wm[152] = 16'h89AB;
		m.wm[153] = 16'hCDEF;
		for (int i = 0; i < 256; i++) ew[i] = m.wm[i];
		for (int i = 0; i < 256; i++) el[i] = m.lm[i];
		repeat (2) @(negedge clk_i);
		rst_n_i = 1'b1;
		chk(busy_o === 1'b0 && done_o === 1'b0 && acc_valid_o === 1'b0 && wr_req_o === 1'b0,
			"reset outputs");
		for (int op = 1; op <= 3; op++) begin
			for (int j = 0; j < 20; j++) acc_op(3'(op), $urandom, $urandom);
		end
		acc_op(3'h3, 32'h87654321, 32'hFEDCBA98);
		acc_op(3'h3, 32'h0F9A1234, 32'h76543210);
		acc_op(3'h3, 32'h11112222, 32'h89ABCDEF);
		acc_op(3'h3, 32'h0, 32'h12345678);
		acc_op(3'h2, 32'h0000017F, 32'h0);
		// Encoder correction for 360 and 720 counts stays with the program
		acc_op(3'h2, 32'hFFFF8200, 32'h0);
		$display("accumulator ops done");
		stall = 1'b1;
		for (int i = 0; i < 6; i++) ew[40+i] = ew[10+i];
		copy(3'h4, 1'b0, 16'd10, 16'd6, 16'd0, 16'd40);
		copy(3'h4, 1'b0, 16'd10, 16'd0, 16'd0, 16'd80);
		for (int i = 0; i < 4; i++) ew[62+i] = el[22+i];
		copy(3'h5, 1'b1, 16'd20, 16'd2, 16'd4, 16'd60);
		for (int i = 0; i < 5; i++) el[123+i] = ew[103+i];
		copy(3'h5, 1'b0, 16'd100, 16'd3, 16'd5, 16'd120);
		for (int i = 0; i < 4; i++) begin
			ew[200+2*i] = {asc(ew[150+i][15:12]), asc(ew[150+i][11:8])};
			ew[201+2*i] = {asc(ew[150+i][7:4]), asc(ew[150+i][3:0])};
		end
		copy(3'h0, 1'b0, 16'd150, 16'd4, 16'd0, 16'd200);
		finish_test;
	end
endmodule
`default_nettype wire
